// ### core/bcrf_pkg.sv
/*
 Shared constants, register indices, decode types and the
 decode function of the banked register file.
 Assumes a single core clock and a plain register port.
*/
package bcrf_pkg;

	localparam int DATA_W     = 16;
	localparam int PC_W       = 20;
	localparam int TABLE_W    = 20;
	localparam int BUS_W      = 32;
	localparam int ADDR_W     = 5;
	localparam int NUM_BANKED = 7;
	localparam int NUM_BANKS  = 2;
	localparam int SLOT_W     = 3;

	// slots of the banked storage
	localparam logic [SLOT_W-1:0] SLOT_DATA_ZERO  = 3'h0;
	localparam logic [SLOT_W-1:0] SLOT_DATA_ONE   = 3'h1;
	localparam logic [SLOT_W-1:0] SLOT_DATA_TWO   = 3'h2;
	localparam logic [SLOT_W-1:0] SLOT_DATA_THREE = 3'h3;
	localparam logic [SLOT_W-1:0] SLOT_ADDR_ZERO  = 3'h4;
	localparam logic [SLOT_W-1:0] SLOT_ADDR_ONE   = 3'h5;
	localparam logic [SLOT_W-1:0] SLOT_FRAME_BASE = 3'h6;

	// register port indices
	localparam logic [ADDR_W-1:0] OFS_DATA_ZERO      = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_DATA_ONE       = 5'h01;
	localparam logic [ADDR_W-1:0] OFS_DATA_TWO       = 5'h02;
	localparam logic [ADDR_W-1:0] OFS_DATA_THREE     = 5'h03;
	localparam logic [ADDR_W-1:0] OFS_ADDR_ZERO      = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_ADDR_ONE       = 5'h05;
	localparam logic [ADDR_W-1:0] OFS_FRAME_BASE     = 5'h06;
	localparam logic [ADDR_W-1:0] OFS_PROGRAM_CNT    = 5'h07;
	localparam logic [ADDR_W-1:0] OFS_FLAGS          = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_USER_STACK     = 5'h09;
	localparam logic [ADDR_W-1:0] OFS_INT_STACK      = 5'h0A;
	localparam logic [ADDR_W-1:0] OFS_STATIC_BASE    = 5'h0B;
	localparam logic [ADDR_W-1:0] OFS_VECTOR_BASE    = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_ACTIVE_STACK   = 5'h0D;
	localparam logic [ADDR_W-1:0] OFS_ZERO_LOW_BYTE  = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_ZERO_HIGH_BYTE = 5'h11;
	localparam logic [ADDR_W-1:0] OFS_ONE_LOW_BYTE   = 5'h12;
	localparam logic [ADDR_W-1:0] OFS_ONE_HIGH_BYTE  = 5'h13;
	localparam logic [ADDR_W-1:0] OFS_PAIR_LOW_WIDE  = 5'h18;
	localparam logic [ADDR_W-1:0] OFS_PAIR_HIGH_WIDE = 5'h19;
	localparam logic [ADDR_W-1:0] OFS_ADDR_PAIR_WIDE = 5'h1A;

	// flag register layout
	localparam int                FLG_BANK_BIT   = 4;
	localparam int                FLG_STACK_BIT  = 7;
	localparam logic [DATA_W-1:0] FLG_WRITE_MASK = 16'h70FF;

	// values after reset
	localparam logic [DATA_W-1:0]  RST_WORD   = 16'h0000;
	localparam logic [PC_W-1:0]    RST_PC     = 20'h00000;
	localparam logic [TABLE_W-1:0] RST_TABLE  = 20'h00000;
	localparam logic [BUS_W-1:0]   RST_RDATA  = 32'h00000000;

	typedef enum logic [2:0] {
		ACC_NONE = 3'b000,
		ACC_WORD = 3'b001,
		ACC_BYTE = 3'b010,
		ACC_WIDE = 3'b011,
		ACC_CORE = 3'b100
	} bcrf_kind_t;

	typedef struct packed {
		bcrf_kind_t        kind;
		logic [SLOT_W-1:0] slot;
		logic [SLOT_W-1:0] hi_slot;
		logic              high_byte;
	} bcrf_dec_t;

	typedef struct packed {
		logic [NUM_BANKS-1:0][NUM_BANKED-1:0][DATA_W-1:0] regs;
	} bcrf_bank_state_t;

	typedef struct packed {
		logic [DATA_W-1:0] user_sp;
		logic [DATA_W-1:0] int_sp;
	} bcrf_stack_state_t;

	function automatic bcrf_dec_t bcrf_decode(input logic [ADDR_W-1:0] a);
		bcrf_dec_t d;
		d = '{kind: ACC_NONE, slot: SLOT_DATA_ZERO, hi_slot: SLOT_DATA_ZERO, high_byte: 1'b0};
		case (a)
			OFS_DATA_ZERO, OFS_DATA_ONE, OFS_DATA_TWO, OFS_DATA_THREE,
			OFS_ADDR_ZERO, OFS_ADDR_ONE, OFS_FRAME_BASE: begin
				d.kind = ACC_WORD;
				d.slot = a[SLOT_W-1:0];
			end
			OFS_ZERO_LOW_BYTE, OFS_ZERO_HIGH_BYTE,
			OFS_ONE_LOW_BYTE, OFS_ONE_HIGH_BYTE: begin
				d.kind      = ACC_BYTE;
				d.slot      = a[1] ? SLOT_DATA_ONE : SLOT_DATA_ZERO;
				d.high_byte = a[0];
			end
			OFS_PAIR_LOW_WIDE: begin
				d.kind    = ACC_WIDE;
				d.slot    = SLOT_DATA_ZERO;
				d.hi_slot = SLOT_DATA_TWO;
			end
			OFS_PAIR_HIGH_WIDE: begin
				d.kind    = ACC_WIDE;
				d.slot    = SLOT_DATA_ONE;
				d.hi_slot = SLOT_DATA_THREE;
			end
			OFS_ADDR_PAIR_WIDE: begin
				d.kind    = ACC_WIDE;
				d.slot    = SLOT_ADDR_ZERO;
				d.hi_slot = SLOT_ADDR_ONE;
			end
			OFS_PROGRAM_CNT, OFS_FLAGS, OFS_USER_STACK, OFS_INT_STACK,
			OFS_STATIC_BASE, OFS_VECTOR_BASE, OFS_ACTIVE_STACK: begin
				d.kind = ACC_CORE;
			end
			default: begin
				d.kind = ACC_NONE;
			end
		endcase
		return d;
	endfunction

endpackage

// ### core/bcrf_bank_if.sv
/*
 Carrier between the register file top and its banked storage.
 Assumes both ends sit on the same core clock.
*/
`timescale 1ns/1ps
interface bcrf_bank_if;
	import bcrf_pkg::*;
	logic                               bank;
	logic [1:0]                         lo_mask;
	logic [SLOT_W-1:0]                  lo_slot;
	logic [DATA_W-1:0]                  lo_data;
	logic [1:0]                         hi_mask;
	logic [SLOT_W-1:0]                  hi_slot;
	logic [DATA_W-1:0]                  hi_data;
	logic [NUM_BANKED-1:0][DATA_W-1:0]  view;

	modport ctrl  (output bank, lo_mask, lo_slot, lo_data, hi_mask, hi_slot, hi_data,
	               input view);
	modport store (input bank, lo_mask, lo_slot, lo_data, hi_mask, hi_slot, hi_data,
	               output view);
endinterface

// ### core/bcrf_bank.sv
/*
 Two banks of the seven banked registers with byte-lane writes.
 Assumes at most two slots are written per cycle, always distinct.
*/
`timescale 1ns/1ps
module bcrf_bank
	import bcrf_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// storage side of the carrier
	bcrf_bank_if.store bus
);

	bcrf_bank_state_t state_reg;
	bcrf_bank_state_t state_next;

	always_comb begin
		state_next = state_reg;
		for (int s = 0; s < NUM_BANKED; s++) begin
			for (int l = 0; l < 2; l++) begin
				// untouched lane keeps its byte
				if (bus.lo_mask[l] && bus.lo_slot == SLOT_W'(s)) begin
					state_next.regs[bus.bank][s][l*8 +: 8] = bus.lo_data[l*8 +: 8];
				end
				if (bus.hi_mask[l] && bus.hi_slot == SLOT_W'(s)) begin
					state_next.regs[bus.bank][s][l*8 +: 8] = bus.hi_data[l*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign bus.view = state_reg.regs[bus.bank];

endmodule

// ### core/bcrf_stack.sv
/*
 User and interrupt stack pointers with active selection.
 Assumes the select flag comes from the flag register.
*/
`timescale 1ns/1ps
module bcrf_stack
	import bcrf_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rstn,
	// control
	input  wire logic              use_user,
	input  wire logic              wr_user,
	input  wire logic              wr_int,
	input  wire logic [DATA_W-1:0] wdata,
	// values
	output logic      [DATA_W-1:0] user_sp,
	output logic      [DATA_W-1:0] int_sp,
	output logic      [DATA_W-1:0] active_sp
);

	bcrf_stack_state_t state_reg;
	bcrf_stack_state_t state_next;

	always_comb begin
		state_next = state_reg;
		if (wr_user) begin
			state_next.user_sp = wdata;
		end
		if (wr_int) begin
			state_next.int_sp = wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state_reg <= '{user_sp: RST_WORD, int_sp: RST_WORD};
		end else begin
			state_reg <= state_next;
		end
	end

	assign user_sp   = state_reg.user_sp;
	assign int_sp    = state_reg.int_sp;
	assign active_sp = use_user ? state_reg.user_sp : state_reg.int_sp;

endmodule

// ### core/bcrf_top.sv
/*
 Register file of a 16-bit core: banked data, address and frame
 registers, program counter, flags, stacks, static and table bases.
 Assumes the datapath drives the plain register port on core_clk,
 never both strobes at once; read data stand one cycle after.

*/
`timescale 1ns/1ps
module bcrf_top
	import bcrf_pkg::*;
(
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               rstn,
	// register port
	input  wire logic [ADDR_W-1:0]  reg_addr,
	input  wire logic [BUS_W-1:0]   reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [BUS_W-1:0]   reg_rdata,
	// program counter advance
	input  wire logic               pc_advance,
	input  wire logic [3:0]         pc_step,
	// addressing bases
	output logic      [DATA_W-1:0]  addr_zero_base,
	output logic      [DATA_W-1:0]  addr_one_base,
	output logic      [BUS_W-1:0]   addr_wide_base,
	output logic      [DATA_W-1:0]  frame_base_out,
	output logic      [DATA_W-1:0]  static_base_out,
	output logic      [DATA_W-1:0]  stack_pointer_out,
	output logic      [TABLE_W-1:0] vector_table_base,
	output logic      [PC_W-1:0]    program_counter,
	// flag state
	output logic      [DATA_W-1:0]  flags_out,
	output logic                    bank_select,
	output logic                    stack_select
);

	typedef struct packed {
		logic [PC_W-1:0]    pc;
		logic [DATA_W-1:0]  flags;
		logic [DATA_W-1:0]  static_base;
		logic [TABLE_W-1:0] table_base;
		logic [BUS_W-1:0]   rdata;
	} bcrf_top_state_t;

	bcrf_top_state_t   state_reg;
	bcrf_top_state_t   state_next;
	bcrf_dec_t         dec;
	logic [BUS_W-1:0]  read_word;
	logic              sp_wr_user;
	logic              sp_wr_int;
	logic [DATA_W-1:0] user_sp;
	logic [DATA_W-1:0] int_sp;
	logic [DATA_W-1:0] active_sp;

	logic [DATA_W-1:0] lo_word;
	logic [DATA_W-1:0] hi_word;
	logic [BUS_W-1:0]  core_word;
	logic              wr_pc;
	logic              wr_flags;
	logic              wr_static;
	logic              wr_table;

	bcrf_bank_if bank_bus ();

	function automatic logic [DATA_W-1:0] slot_value(
		input logic [NUM_BANKED-1:0][DATA_W-1:0] v,
		input logic [SLOT_W-1:0]                 s
	);
		return v[s];
	endfunction

	assign dec = bcrf_decode(reg_addr);

	// words of the selected bank named by the decode
	assign lo_word = slot_value(bank_bus.view, dec.slot);
	assign hi_word = slot_value(bank_bus.view, dec.hi_slot);

	// banked storage follows the live bank flag
	assign bank_bus.bank = state_reg.flags[FLG_BANK_BIT];

	always_comb begin
		bank_bus.lo_mask = 2'b00;
		bank_bus.hi_mask = 2'b00;
		bank_bus.lo_slot = dec.slot;
		bank_bus.hi_slot = dec.hi_slot;
		bank_bus.lo_data = reg_wdata[DATA_W-1:0];
		bank_bus.hi_data = reg_wdata[BUS_W-1:DATA_W];
		if (reg_wr) begin
			case (dec.kind)
				ACC_WORD: begin
					bank_bus.lo_mask = 2'b11;
				end
				ACC_BYTE: begin
					// byte sits in the low bits of the write data
					bank_bus.lo_mask = dec.high_byte ? 2'b10 : 2'b01;
					bank_bus.lo_data = {reg_wdata[7:0], reg_wdata[7:0]};
				end
				ACC_WIDE: begin
					bank_bus.lo_mask = 2'b11;
					bank_bus.hi_mask = 2'b11;
				end
				default: begin
					bank_bus.lo_mask = 2'b00;
				end
			endcase
		end
	end

	// one store holds both copies; the flag picks the live one
	bcrf_bank u_bank (
		.core_clk (core_clk),
		.rstn     (rstn),
		.bus      (bank_bus)
	);

	// the alias writes whichever pointer the flag selects
	always_comb begin
		sp_wr_user = 1'b0;
		sp_wr_int  = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				OFS_USER_STACK: begin
					sp_wr_user = 1'b1;
				end
				OFS_INT_STACK: begin
					sp_wr_int = 1'b1;
				end
				OFS_ACTIVE_STACK: begin
					sp_wr_user = state_reg.flags[FLG_STACK_BIT];
					sp_wr_int  = !state_reg.flags[FLG_STACK_BIT];
				end
				default: begin
					sp_wr_user = 1'b0;
				end
			endcase
		end
	end

	// select flag is live: a flag write moves the pointer next cycle
	bcrf_stack u_stack (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.use_user  (state_reg.flags[FLG_STACK_BIT]),
		.wr_user   (sp_wr_user),
		.wr_int    (sp_wr_int),
		.wdata     (reg_wdata[DATA_W-1:0]),
		.user_sp   (user_sp),
		.int_sp    (int_sp),
		.active_sp (active_sp)
	);

	// unbanked registers, zero-extended to the bus
	always_comb begin
		core_word = '0;
		case (reg_addr)
			OFS_PROGRAM_CNT: begin
				core_word = {12'h000, state_reg.pc};
			end
			OFS_FLAGS: begin
				core_word = {16'h0000, state_reg.flags};
			end
			OFS_USER_STACK: begin
				core_word = {16'h0000, user_sp};
			end
			OFS_INT_STACK: begin
				core_word = {16'h0000, int_sp};
			end
			OFS_STATIC_BASE: begin
				core_word = {16'h0000, state_reg.static_base};
			end
			OFS_VECTOR_BASE: begin
				core_word = {12'h000, state_reg.table_base};
			end
			OFS_ACTIVE_STACK: begin
				core_word = {16'h0000, active_sp};
			end
			default: begin
				core_word = '0;
			end
		endcase
	end

	// read mux over the selected bank and the unbanked registers
	// unmapped indices fall to the default and read back zero
	always_comb begin
		read_word = '0;
		case (dec.kind)
			ACC_WORD: begin
				read_word = {16'h0000, lo_word};
			end
			ACC_BYTE: begin
				if (dec.high_byte) begin
					read_word = {24'h000000, lo_word[15:8]};
				end else begin
					read_word = {24'h000000, lo_word[7:0]};
				end
			end
			ACC_WIDE: begin
				read_word = {hi_word, lo_word};
			end
			ACC_CORE: begin
				read_word = core_word;
			end
			default: begin
				read_word = '0;
			end
		endcase
	end

	// one enable per unbanked core register
	always_comb begin
		wr_pc     = 1'b0;
		wr_flags  = 1'b0;
		wr_static = 1'b0;
		wr_table  = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				OFS_PROGRAM_CNT: begin
					wr_pc = 1'b1;
				end
				OFS_FLAGS: begin
					wr_flags = 1'b1;
				end
				OFS_STATIC_BASE: begin
					wr_static = 1'b1;
				end
				OFS_VECTOR_BASE: begin
					wr_table = 1'b1;
				end
				default: begin
					// an unmapped index matches nothing and writes nothing
					wr_pc = 1'b0;
				end
			endcase
		end
	end

	always_comb begin
		state_next = state_reg;
		// read data valid only in the cycle after the strobe
		state_next.rdata = reg_rd ? read_word : RST_RDATA;
		// advance wraps at the counter width
		if (pc_advance) begin
			state_next.pc = state_reg.pc + PC_W'(pc_step);
		end
		if (wr_pc) begin
			// a load beats an advance in the same cycle
			state_next.pc = reg_wdata[PC_W-1:0];
		end
		if (wr_flags) begin
			// reserved bits stay zero
			state_next.flags = reg_wdata[DATA_W-1:0] & FLG_WRITE_MASK;
		end
		if (wr_static) begin
			state_next.static_base = reg_wdata[DATA_W-1:0];
		end
		if (wr_table) begin
			state_next.table_base = reg_wdata[TABLE_W-1:0];
		end
	end

	// synchronous reset clears every unbanked register and the read data
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state_reg <= '{pc: RST_PC, flags: RST_WORD, static_base: RST_WORD,
			               table_base: RST_TABLE, rdata: RST_RDATA};
		end else begin
			state_reg <= state_next;
		end
	end

	// banked bases follow the selected bank with no extra cycle
	assign reg_rdata         = state_reg.rdata;
	assign addr_zero_base    = bank_bus.view[SLOT_ADDR_ZERO];
	assign addr_one_base     = bank_bus.view[SLOT_ADDR_ONE];
	assign addr_wide_base    = {bank_bus.view[SLOT_ADDR_ONE],
	                            bank_bus.view[SLOT_ADDR_ZERO]};
	assign frame_base_out    = bank_bus.view[SLOT_FRAME_BASE];
	assign static_base_out   = state_reg.static_base;
	assign stack_pointer_out = active_sp;
	assign vector_table_base = state_reg.table_base;
	assign program_counter   = state_reg.pc;
	assign flags_out         = state_reg.flags;
	assign bank_select       = state_reg.flags[FLG_BANK_BIT];
	assign stack_select      = state_reg.flags[FLG_STACK_BIT];

endmodule

// ### test/bcrf_props.sv
/*
 Port checker for the banked register file.
 Assumes it is bound onto bcrf_top and sees only its ports.
*/
`timescale 1ns/1ps
module bcrf_props
	import bcrf_pkg::*;
(
	// clock and reset
	input wire logic               core_clk,
	input wire logic               rstn,
	// register port
	input wire logic [ADDR_W-1:0]  reg_addr,
	input wire logic [BUS_W-1:0]   reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [BUS_W-1:0]   reg_rdata,
	// program counter
	input wire logic               pc_advance,
	input wire logic [3:0]         pc_step,
	input wire logic [PC_W-1:0]    program_counter,
	// bases and flags
	input wire logic [DATA_W-1:0]  addr_zero_base,
	input wire logic [DATA_W-1:0]  addr_one_base,
	input wire logic [BUS_W-1:0]   addr_wide_base,
	input wire logic [DATA_W-1:0]  flags_out,
	input wire logic               bank_select,
	input wire logic               stack_select
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence s_rd_addr_zero;
		reg_rd && reg_addr == 5'h04;
	endsequence
	sequence s_pc_load;
		reg_wr && reg_addr == 5'h07;
	endsequence
	sequence s_flag_load;
		reg_wr && reg_addr == 5'h08;
	endsequence

	a_rdata_idle_zero:
		assert property (!reg_rd |=> reg_rdata == 32'h00000000) else $error("read data not idle");
	a_rdata_selected_bank:
		assert property (s_rd_addr_zero |=> reg_rdata == {16'h0000, $past(addr_zero_base)})
		else $error("read of address zero not from selected bank");
	a_pc_load_value:
		assert property (s_pc_load |=> program_counter == $past(reg_wdata[19:0]))
		else $error("program counter load wrong");
	a_pc_step_add:
		assert property (pc_advance && !(reg_wr && reg_addr == 5'h07) |=>
			program_counter == $past(program_counter) + $past(pc_step))
		else $error("program counter advance wrong");
	a_pc_hold_idle:
		assert property (!pc_advance && !reg_wr |=> $stable(program_counter))
		else $error("program counter moved");
	a_flag_write_mask:
		assert property (s_flag_load |=> flags_out == ($past(reg_wdata[15:0]) & 16'h70FF))
		else $error("flag write wrong");
	a_bank_follows_flag:
		assert property (bank_select == flags_out[4]) else $error("bank select mismatch");
	a_stack_follows_flag:
		assert property (stack_select == flags_out[7]) else $error("stack select mismatch");
	a_addr_wide_join:
		assert property (addr_wide_base == {addr_one_base, addr_zero_base})
		else $error("wide address pair wrong");
endmodule

bind bcrf_top bcrf_props i_props (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .pc_advance, .pc_step, .program_counter, .addr_zero_base, .addr_one_base,
	.addr_wide_base, .flags_out, .bank_select, .stack_select);

// ### test/bcrf_dp_model.sv
/*
 Datapath model that masters the register port.
 Assumes one core clock; read data stand one cycle after the strobe.
*/
`timescale 1ns/1ps
module bcrf_dp_model
	import bcrf_pkg::*;
(
	// clock
	input  wire logic              core_clk,
	// register port
	output logic      [ADDR_W-1:0] reg_addr,
	output logic      [BUS_W-1:0]  reg_wdata,
	output logic                   reg_wr,
	output logic                   reg_rd,
	input  wire logic [BUS_W-1:0]  reg_rdata
);
	initial begin
		reg_addr = 5'h00;
		reg_wdata = 32'h00000000;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
	end

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge core_clk);
		reg_wr <= 1'h0;
		// stale data must not look like a valid write
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [BUS_W-1:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask
endmodule

// ### test/tb.sv
/*
 Self-checking bench for the banked register file.
 Assumes the datapath model masters the register port.
*/
`timescale 1ns/1ps
module tb;
	import bcrf_pkg::*;
	logic               core_clk;
	logic               rstn;
	logic [ADDR_W-1:0]  reg_addr;
	logic [BUS_W-1:0]   reg_wdata;
	logic               reg_wr;
	logic               reg_rd;
	logic [BUS_W-1:0]   reg_rdata;
	logic               pc_advance;
	logic [3:0]         pc_step;
	logic [DATA_W-1:0]  addr_zero_base;
	logic [DATA_W-1:0]  addr_one_base;
	logic [BUS_W-1:0]   addr_wide_base;
	logic [DATA_W-1:0]  frame_base_out;
	logic [DATA_W-1:0]  static_base_out;
	logic [DATA_W-1:0]  stack_pointer_out;
	logic [TABLE_W-1:0] vector_table_base;
	logic [PC_W-1:0]    program_counter;
	logic [DATA_W-1:0]  flags_out;
	logic               bank_select;
	logic               stack_select;
	int                 num_errors;
	int                 n_compared;
	logic [BUS_W-1:0]   d;

	bcrf_dp_model i_dp (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	bcrf_top i_dut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.pc_advance, .pc_step, .addr_zero_base, .addr_one_base, .addr_wide_base,
		.frame_base_out, .static_base_out, .stack_pointer_out, .vector_table_base,
		.program_counter, .flags_out, .bank_select, .stack_select);

	initial begin
		core_clk = 1'h0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic check_val(input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic t_reset();
		for (int i = 0; i < 14; i++) begin
			i_dp.rd(i[4:0], d);
			check_val(d, 32'h00000000);
		end
		$display("reset values done");
	endtask

	task automatic t_banks();
		for (int b = 0; b < 2; b++) begin
			i_dp.wr(5'h08, {27'h0, b[0], 4'h0});
			for (int r = 0; r < 7; r++) begin
				i_dp.wr(r[4:0], {16'h0, 4'hB, b[3:0], 4'h0, r[3:0]});
			end
		end
		for (int b = 1; b >= 0; b--) begin
			i_dp.wr(5'h08, {27'h0, b[0], 4'h0});
			for (int r = 0; r < 7; r++) begin
				i_dp.rd(r[4:0], d);
				check_val(d, {16'h0, 4'hB, b[3:0], 4'h0, r[3:0]});
			end
			check_val({31'h0, bank_select}, {31'h0, b[0]});
			check_val({16'h0, addr_zero_base}, {16'h0, 4'hB, b[3:0], 8'h04});
			check_val({16'h0, frame_base_out}, {16'h0, 4'hB, b[3:0], 8'h06});
		end
		$display("bank test done");
	endtask

	task automatic t_bytes();
		i_dp.wr(5'h00, 32'h0000A5C3);
		i_dp.wr(5'h11, 32'hFFFFFF3C);
		i_dp.rd(5'h00, d);
		check_val(d, 32'h00003CC3);
		i_dp.wr(5'h12, 32'h0000005A);
		i_dp.rd(5'h01, d);
		check_val(d, 32'h0000B05A);
		i_dp.rd(5'h13, d);
		check_val(d, 32'h000000B0);
		i_dp.rd(5'h10, d);
		check_val(d, 32'h000000C3);
		i_dp.wr(5'h13, 32'h000000E7);
		i_dp.rd(5'h01, d);
		check_val(d, 32'h0000E75A);
		i_dp.wr(5'h10, 32'h00000099);
		i_dp.rd(5'h00, d);
		check_val(d, 32'h00003C99);
		$display("byte test done");
	endtask

	task automatic t_wide();
		i_dp.wr(5'h18, 32'h12345678);
		i_dp.rd(5'h02, d);
		check_val(d, 32'h00001234);
		i_dp.rd(5'h00, d);
		check_val(d, 32'h00005678);
		i_dp.wr(5'h19, 32'h9ABCDEF0);
		i_dp.rd(5'h03, d);
		check_val(d, 32'h00009ABC);
		i_dp.wr(5'h1A, 32'hCAFE0123);
		i_dp.rd(5'h05, d);
		check_val(d, 32'h0000CAFE);
		check_val(addr_wide_base, 32'hCAFE0123);
		check_val({16'h0, addr_one_base}, 32'h0000CAFE);
		$display("wide test done");
	endtask

	task automatic t_pc();
		i_dp.wr(5'h07, 32'h000FFFFE);
		@(posedge core_clk);
		pc_step <= 4'h3;
		pc_advance <= 1'h1;
		@(posedge core_clk);
		pc_advance <= 1'h0;
		@(negedge core_clk);
		check_val({12'h0, program_counter}, 32'h00000001);
		// load and advance in one cycle: the load must win
		fork
			i_dp.wr(5'h07, 32'h00012345);
			begin
				@(posedge core_clk);
				pc_advance <= 1'h1;
				@(posedge core_clk);
				pc_advance <= 1'h0;
			end
		join
		@(negedge core_clk);
		check_val({12'h0, program_counter}, 32'h00012345);
		$display("pc test done");
	endtask

	task automatic t_misc();
		i_dp.wr(5'h08, 32'h0000FFFF);
		i_dp.rd(5'h08, d);
		check_val(d, 32'h000070FF);
		check_val({16'h0, flags_out}, 32'h000070FF);
		check_val({31'h0, bank_select}, 32'h00000001);
		check_val({31'h0, stack_select}, 32'h00000001);
		i_dp.wr(5'h09, 32'h00001111);
		i_dp.wr(5'h0A, 32'h00002222);
		@(negedge core_clk);
		check_val({16'h0, stack_pointer_out}, 32'h00001111);
		i_dp.wr(5'h08, 32'h00000000);
		@(negedge core_clk);
		check_val({16'h0, stack_pointer_out}, 32'h00002222);
		i_dp.wr(5'h0D, 32'h00003333);
		i_dp.rd(5'h0A, d);
		check_val(d, 32'h00003333);
		i_dp.rd(5'h09, d);
		check_val(d, 32'h00001111);
		i_dp.wr(5'h0C, 32'hFFFABCDE);
		i_dp.rd(5'h0C, d);
		check_val(d, 32'h000ABCDE);
		check_val({12'h0, vector_table_base}, 32'h000ABCDE);
		i_dp.wr(5'h0B, 32'h00004321);
		@(negedge core_clk);
		check_val({16'h0, static_base_out}, 32'h00004321);
		i_dp.wr(5'h0E, 32'h00005555);
		i_dp.rd(5'h0E, d);
		check_val(d, 32'h00000000);
		$display("flag and stack test done");
	endtask

	initial begin
		rstn = 1'h0;
		pc_advance = 1'h0;
		pc_step = 4'h0;
		num_errors = 0;
		n_compared = 0;
		repeat (6) @(posedge core_clk);
		rstn <= 1'h1;
		t_reset();
		t_banks();
		t_bytes();
		t_wide();
		t_pc();
		t_misc();
		complete_run();
	end

	// run needs well under a thousand cycles
	initial begin
		#200000;
		num_errors++;
		complete_run();
	end
endmodule
